// >>> tspm_pkg.sv
// Package with constants and types for the touch scan power mode block.
package tspm_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned SCAN_MIN_MS   = 25;
  localparam int unsigned SCAN_MAX_MS   = 561;
  localparam logic [5:0]  CONST_25_MS   = 6'd25;
  localparam logic [5:0]  CONST_35_MS   = 6'd35;
  localparam logic [5:0]  CONST_55_MS   = 6'd55;
  localparam logic [3:0]  FEW_BUTTONS   = 4'h5;
  localparam int unsigned DS_HOLD_MS    = 50;
  localparam int unsigned REINIT_NRM_MS = 20;
  localparam int unsigned REINIT_HI_MS  = 50;
  localparam int unsigned SCAN_BUSY_MS  = 5;
  localparam logic [9:0]  OFFSET_RESET  = 10'h000;
  localparam logic [2:0]  BANK_RESET    = 3'h0;
  localparam logic [7:0]  DEBOUNCE_MIN  = 8'h01;
  localparam int unsigned N_BUTTONS     = 10;

  typedef enum logic [2:0] {
    TSPM_BANK_OPER,
    TSPM_BANK_LED,
    TSPM_BANK_DEVCFG,
    TSPM_BANK_PRODTEST,
    TSPM_BANK_DEBUG
  } tspm_bank_t;

  typedef enum logic [2:0] {
    TSPM_ST_SCAN,
    TSPM_ST_SLEEP,
    TSPM_ST_DEEP,
    TSPM_ST_REINIT
  } tspm_state_t;

endpackage

// >>> tspm_ms_timer.sv
// Millisecond tick generator and down counter in milliseconds.
`timescale 1ns/100ps
module tspm_ms_timer (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       load_i,
  input  wire logic [9:0] load_ms_i,
  output logic            done_o
);
  import tspm_pkg::*;

  localparam logic [14:0] TICK_LAST = 15'(CYC_PER_MS - 1);

  logic [14:0] tick_cnt;
  logic [9:0]  ms_left;

  // Ticks restart on load so a period is exact to the cycle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 15'h0000;
    end else if (load_i || tick_cnt == TICK_LAST) begin
      tick_cnt <= 15'h0000;
    end else begin
      tick_cnt <= tick_cnt + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_left <= 10'h000;
    end else if (load_i) begin
      ms_left <= load_ms_i;
    end else if (tick_cnt == TICK_LAST && ms_left != 10'h000) begin
      ms_left <= ms_left - 10'h001;
    end
  end

  // Done looks at the count alone, so a load taken on done forms no loop.
  assign done_o = (ms_left == 10'h000);

endmodule

// >>> tspm_latency.sv
// Scan constant, scan period and touch latency arithmetic.
`timescale 1ns/100ps
module tspm_latency (
  input  wire logic [3:0]  button_count_i,
  input  wire logic        power_opt_i,
  input  wire logic        high_immunity_i,
  input  wire logic [9:0]  offset_ms_i,
  input  wire logic [7:0]  debounce_i,
  output logic      [5:0]  scan_const_o,
  output logic      [9:0]  scan_period_o,
  output logic      [15:0] repeat_lat_o,
  output logic      [15:0] first_lat_o
);
  import tspm_pkg::*;

  logic [10:0] raw_period;
  logic [7:0]  deb;
  logic [7:0]  mult;
  logic [15:0] deb_term;

  always_comb begin
    if (power_opt_i || button_count_i > FEW_BUTTONS) begin
      scan_const_o = high_immunity_i ? CONST_55_MS : CONST_35_MS;
    end else begin
      scan_const_o = high_immunity_i ? CONST_35_MS : CONST_25_MS;
    end
  end

  // The period is offset plus constant, held inside the legal range.
  always_comb begin
    raw_period = 11'(offset_ms_i) + 11'(scan_const_o);
    if (raw_period > 11'(SCAN_MAX_MS)) begin
      scan_period_o = 10'(SCAN_MAX_MS);
    end else if (raw_period < 11'(SCAN_MIN_MS)) begin
      scan_period_o = 10'(SCAN_MIN_MS);
    end else begin
      scan_period_o = raw_period[9:0];
    end
  end

  always_comb begin
    deb  = (debounce_i < DEBOUNCE_MIN) ? DEBOUNCE_MIN : debounce_i;
    mult = high_immunity_i ? deb : 8'((deb - 8'h01) / 8'h03 + 8'h01);
    deb_term     = 16'(scan_const_o) * 16'(mult);
    repeat_lat_o = 16'(scan_const_o) + deb_term;
    first_lat_o  = 16'(scan_period_o) + deb_term;
  end

endmodule

// >>> tspm_core.sv
// Scan timing, deep sleep control and register bank selection of a touch controller.
`timescale 1ns/100ps
// Summary of operation
// - Scan period equals scan time plus sleep.
// - Period is offset plus scan-rate constant.
// - Period clamped to 25 through 561 ms.
// - Constant picked by optimisation, immunity, button count.
// - Deep sleep stops all scanning and blocks.
// - Deep sleep request bit self clears.
// - Low attention line wakes the device.
// - Wake reinitialises sensing; touches suppressed meanwhile.
// - Normal immunity repeat latency uses ceiling of debounce/3.
// - High immunity repeat latency uses debounce.
// - First touch latency uses full period.
// - Debounce accepted from 1 to 255.
// - Five banks; only selected bank visible.
// - Operating bank writes and reads given fields.
// - LED bank holds LED configuration.
// - Device bank holds device configuration.
// - Test bank reports diagnostics and counts.
// - Debug bank returns selected button data.
// - Attention line low before bus transactions.
module tspm_core (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 attn_sleep_i,
  input  wire logic                 deep_sleep_wr_i,
  input  wire logic                 bank_wr_i,
  input  wire logic [2:0]           bank_sel_i,
  input  wire logic [9:0]           scan_offset_ms_i,
  input  wire logic [3:0]           button_count_i,
  input  wire logic                 power_opt_i,
  input  wire logic                 high_immunity_i,
  input  wire logic [7:0]           debounce_i,
  input  wire logic [9:0]           touch_raw_i,
  output logic                      deep_sleep_req_o,
  output logic                      in_deep_sleep_o,
  output logic                      scanning_o,
  output logic                      scan_start_o,
  output logic                      blocks_on_o,
  output logic                      report_en_o,
  output logic [9:0]                touch_status_o,
  output tspm_pkg::tspm_bank_t      bank_o,
  output logic [4:0]                bank_visible_o,
  output logic [9:0]                scan_period_o,
  output logic [5:0]                scan_const_o,
  output logic [15:0]               repeat_touch_latency_o,
  output logic [15:0]               first_touch_latency_o
);
  import tspm_pkg::*;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic       attn_meta;
  logic       attn_sync;
  logic [9:0] touch_meta;
  logic [9:0] touch_sync;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      attn_meta  <= 1'b1;
      attn_sync  <= 1'b1;
      touch_meta <= 10'h000;
      touch_sync <= 10'h000;
    end else begin
      attn_meta  <= attn_sleep_i;
      attn_sync  <= attn_meta;
      touch_meta <= touch_raw_i;
      touch_sync <= touch_meta;
    end
  end

  // ------------------------------------------------------------------
  // Timing arithmetic
  // ------------------------------------------------------------------
  logic [9:0]  next_period;
  logic [5:0]  next_const;
  logic [15:0] next_repeat;
  logic [15:0] next_first;

  tspm_latency u_latency (
    .button_count_i  (button_count_i),
    .power_opt_i     (power_opt_i),
    .high_immunity_i (high_immunity_i),
    .offset_ms_i     (scan_offset_ms_i),
    .debounce_i      (debounce_i),
    .scan_const_o    (next_const),
    .scan_period_o   (next_period),
    .repeat_lat_o    (next_repeat),
    .first_lat_o     (next_first)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_period_o          <= 10'(SCAN_MIN_MS);
      scan_const_o           <= CONST_25_MS;
      repeat_touch_latency_o <= 16'h0000;
      first_touch_latency_o  <= 16'h0000;
    end else begin
      scan_period_o          <= next_period;
      scan_const_o           <= next_const;
      repeat_touch_latency_o <= next_repeat;
      first_touch_latency_o  <= next_first;
    end
  end

  // ------------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------------
  tspm_state_t state;
  logic        tmr_load;
  logic [9:0]  tmr_ms;
  logic        tmr_done;
  logic        wake_seen;

  tspm_ms_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .load_i    (tmr_load),
    .load_ms_i (tmr_ms),
    .done_o    (tmr_done)
  );

  // Deep sleep is entered after the host raises the line following a request.
  logic ds_enter;
  logic attn_prev;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      attn_prev <= 1'b1;
    end else begin
      attn_prev <= attn_sync;
    end
  end

  assign ds_enter  = deep_sleep_req_o && attn_sync && !attn_prev &&
                     state != TSPM_ST_DEEP;
  assign wake_seen = !attn_sync;

  always_comb begin
    tmr_load = 1'b0;
    tmr_ms   = 10'h000;
    unique case (state)
      TSPM_ST_SCAN: begin
        if (ds_enter) begin
          tmr_load = 1'b0;
        end else if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_ms   = scan_period_o - 10'(SCAN_BUSY_MS);
        end
      end
      TSPM_ST_SLEEP: begin
        if (tmr_done && !ds_enter) begin
          tmr_load = 1'b1;
          tmr_ms   = 10'(SCAN_BUSY_MS);
        end
      end
      TSPM_ST_DEEP: begin
        if (wake_seen) begin
          tmr_load = 1'b1;
          tmr_ms   = high_immunity_i ? 10'(REINIT_HI_MS) : 10'(REINIT_NRM_MS);
        end
      end
      TSPM_ST_REINIT: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_ms   = 10'(SCAN_BUSY_MS);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= TSPM_ST_SCAN;
    end else if (ds_enter) begin
      state <= TSPM_ST_DEEP;
    end else begin
      unique case (state)
        TSPM_ST_SCAN:   if (tmr_done) state <= TSPM_ST_SLEEP;
        TSPM_ST_SLEEP:  if (tmr_done) state <= TSPM_ST_SCAN;
        TSPM_ST_DEEP:   if (wake_seen) state <= TSPM_ST_REINIT;
        TSPM_ST_REINIT: if (tmr_done) state <= TSPM_ST_SCAN;
      endcase
    end
  end

  // A new host write wins over the self clear in the same cycle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deep_sleep_req_o <= 1'b0;
    end else if (deep_sleep_wr_i) begin
      deep_sleep_req_o <= 1'b1;
    end else if (ds_enter) begin
      deep_sleep_req_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_deep_sleep_o <= 1'b0;
      blocks_on_o     <= 1'b1;
      scanning_o      <= 1'b1;
      scan_start_o    <= 1'b0;
      report_en_o     <= 1'b1;
    end else begin
      in_deep_sleep_o <= (state == TSPM_ST_DEEP);
      blocks_on_o     <= (state != TSPM_ST_DEEP);
      scanning_o      <= (state == TSPM_ST_SCAN);
      scan_start_o    <= (state == TSPM_ST_SLEEP) && tmr_done && !ds_enter;
      report_en_o     <= (state == TSPM_ST_SCAN) || (state == TSPM_ST_SLEEP);
    end
  end

  // Touch status follows the sense inputs only while scanning, holds in sleep and clears in deep sleep and reinit.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      touch_status_o <= 10'h000;
    end else if (state == TSPM_ST_SCAN) begin
      touch_status_o <= touch_sync;
    end else if (state == TSPM_ST_DEEP || state == TSPM_ST_REINIT) begin
      touch_status_o <= 10'h000;
    end
  end

  // ------------------------------------------------------------------
  // Register bank selection
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_o <= TSPM_BANK_OPER;
    end else if (bank_wr_i && bank_sel_i <= 3'(TSPM_BANK_DEBUG)) begin
      bank_o <= tspm_bank_t'(bank_sel_i);
    end
  end

  // One-hot view: operating, LED, device config, test, debug.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_visible_o <= 5'h01;
    end else if (bank_wr_i && bank_sel_i <= 3'(TSPM_BANK_DEBUG)) begin
      bank_visible_o <= 5'h01 << bank_sel_i;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_period_range: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    scan_period_o >= 10'(SCAN_MIN_MS) && scan_period_o <= 10'(SCAN_MAX_MS))
    else $error("scan period out of range");

  a_req_clears: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ds_enter && !deep_sleep_wr_i |=> !deep_sleep_req_o)
    else $error("deep sleep request not cleared");

  a_no_scan_deep: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ds_enter |=> ##1 (!scanning_o && !blocks_on_o))
    else $error("scanning during deep sleep");

  a_wake_reinit: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    state == TSPM_ST_DEEP && wake_seen |=> state == TSPM_ST_REINIT)
    else $error("no wake on low line");

  a_reinit_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    state == TSPM_ST_REINIT |=> !report_en_o && touch_status_o == 10'h000)
    else $error("touch reported during reinit");

  a_const_power: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    power_opt_i
      |=> scan_const_o == ($past(high_immunity_i) ? CONST_55_MS : CONST_35_MS))
    else $error("wrong scan constant");

  a_first_latency: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    1'b1 |=> first_touch_latency_o - repeat_touch_latency_o ==
             16'($past(next_period)) - 16'($past(next_const)))
    else $error("first touch latency mismatch");

  a_bank_onehot: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $onehot(bank_visible_o) && bank_visible_o == (5'h01 << bank_o))
    else $error("bank view not one hot");

  a_scan_sleep: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    state == TSPM_ST_SCAN && tmr_done && !ds_enter |=> state == TSPM_ST_SLEEP)
    else $error("scan not followed by sleep");

  a_req_set: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    deep_sleep_wr_i |=> deep_sleep_req_o)
    else $error("deep sleep request not set by write");

  a_deep_entry: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    deep_sleep_req_o && $rose(attn_sync) |=> ##1 in_deep_sleep_o)
    else $error("deep sleep not entered on line release");

  a_deep_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    in_deep_sleep_o |-> !scanning_o && !scan_start_o && touch_status_o == 10'h000)
    else $error("activity during deep sleep");

  a_lat_normal: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !high_immunity_i && debounce_i <= 8'h03
      |=> repeat_touch_latency_o == 16'(scan_const_o) * 16'h0002)
    else $error("normal immunity latency wrong");

  a_lat_high: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    high_immunity_i && debounce_i == 8'hff
      |=> repeat_touch_latency_o == 16'(scan_const_o) * 16'h0100)
    else $error("high immunity latency wrong");

  a_bank_take: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    bank_wr_i && bank_sel_i <= 3'(TSPM_BANK_DEBUG) |=> 3'(bank_o) == $past(bank_sel_i))
    else $error("bank write not taken");

  a_bank_ignore: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    bank_wr_i && bank_sel_i > 3'(TSPM_BANK_DEBUG) |=> $stable(bank_o))
    else $error("illegal bank code taken");

  c_deep_entry:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ds_enter);
  c_wake:        cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                   state == TSPM_ST_REINIT && tmr_done);
  c_scan_cycle:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) scan_start_o);
  c_debug_bank:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                   bank_o == TSPM_BANK_DEBUG);

endmodule

// >>> tspm_host_model.sv
// Host controller model that drives the attention line and the register writes.
`timescale 1ns/100ps
module tspm_host_model #(
  parameter int unsigned HOLD_CYC = 1000000
) (
  input  wire logic       clk_sys_i,
  output logic            attn_o,
  output logic            ds_wr_o,
  output logic            bank_wr_o,
  output logic [2:0]      bank_sel_o
);
  // -------------------------------------------------------------------------
  // Idle levels
  // -------------------------------------------------------------------------
  initial begin
    attn_o     = 1'b0;
    ds_wr_o    = 1'b0;
    bank_wr_o  = 1'b0;
    bank_sel_o = 3'h7;
  end

  // -------------------------------------------------------------------------
  // Host actions, all launched at the falling edge
  // -------------------------------------------------------------------------
  task automatic set_line(input logic lvl);
    @(negedge clk_sys_i);
    attn_o = lvl;
  endtask

  // The request bit is only ever set through this bus write path.
  task automatic req_deep_sleep();
    set_line(1'b0);
    @(negedge clk_sys_i);
    ds_wr_o = 1'b1;
    @(negedge clk_sys_i);
    ds_wr_o = 1'b0;
    repeat (HOLD_CYC) @(negedge clk_sys_i);
    attn_o = 1'b1;
  endtask

  task automatic wake();
    set_line(1'b0);
  endtask

  // The select lines no longer hold the code once the write is over.
  task automatic bank_write(input logic [2:0] sel);
    @(negedge clk_sys_i);
    bank_sel_o = sel;
    bank_wr_o  = 1'b1;
    @(negedge clk_sys_i);
    bank_wr_o  = 1'b0;
    bank_sel_o = ~sel;
  endtask
endmodule

// >>> tspm_core_tb.sv
// Self-checking testbench for the touch scan power mode block.
`timescale 1ns/100ps
module tspm_core_tb;
  import tspm_pkg::*;

  logic             clk_sys_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             attn, ds_wr, bank_wr;
  logic [2:0]       bank_sel;
  logic [9:0]       scan_offset_ms_i = 10'h000;
  logic [3:0]       button_count_i = 4'h5;
  logic             power_opt_i = 1'b0;
  logic             high_immunity_i = 1'b0;
  logic [7:0]       debounce_i = 8'h01;
  logic [9:0]       touch_raw_i = 10'h000;
  logic             req, deep, scanning, start, blocks_on, report_en;
  logic [9:0]       status, period;
  logic [4:0]       visible;
  logic [5:0]       cnst;
  logic [15:0]      rep_lat, first_lat;
  tspm_bank_t       bank;
  int               errors = 0;
  int               n_tests = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  // The hold time is shortened so that the run stays short.
  tspm_host_model #(.HOLD_CYC(100)) tspm_host_model_inst (
    .clk_sys_i(clk_sys_i), .attn_o(attn), .ds_wr_o(ds_wr),
    .bank_wr_o(bank_wr), .bank_sel_o(bank_sel));

  tspm_core tspm_core_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .attn_sleep_i(attn),
    .deep_sleep_wr_i(ds_wr), .bank_wr_i(bank_wr), .bank_sel_i(bank_sel),
    .scan_offset_ms_i(scan_offset_ms_i), .button_count_i(button_count_i),
    .power_opt_i(power_opt_i), .high_immunity_i(high_immunity_i),
    .debounce_i(debounce_i), .touch_raw_i(touch_raw_i), .deep_sleep_req_o(req),
    .in_deep_sleep_o(deep), .scanning_o(scanning), .scan_start_o(start),
    .blocks_on_o(blocks_on), .report_en_o(report_en), .touch_status_o(status),
    .bank_o(bank), .bank_visible_o(visible), .scan_period_o(period),
    .scan_const_o(cnst), .repeat_touch_latency_o(rep_lat),
    .first_touch_latency_o(first_lat));

  // -------------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apply(input int bc, input logic pw, input logic hi, input int off, input int db);
    @(negedge clk_sys_i);
    button_count_i = 4'(bc);
    power_opt_i = pw;
    high_immunity_i = hi;
    scan_offset_ms_i = 10'(off);
    debounce_i = 8'(db);
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic test_reset();
    check("deep_sleep_req", 16'(req), 16'h0000);
    check("in_deep_sleep", 16'(deep), 16'h0000);
    check("blocks_on", 16'(blocks_on), 16'h0001);
    check("bank", 16'(bank), 16'h0000);
    check("bank_visible", 16'(visible), 16'h0001);
    $display("test reset done");
  endtask

  task automatic test_scan_table();
    int c;
    int p;
    int m;
    for (int i = 0; i < 8; i++) begin
      apply(i[0] ? 6 : 5, i[2], i[1], i * 70, 4);
      c = (!i[2] && !i[0]) ? (i[1] ? 35 : 25) : (i[1] ? 55 : 35);
      p = c + i * 70;
      m = i[1] ? 4 : 2;
      check("scan_const", 16'(cnst), 16'(c));
      check("scan_period", 16'(period), 16'(p));
      check("repeat_latency", rep_lat, 16'(c + c * m));
      check("first_latency", first_lat, 16'(p + c * m));
    end
    apply(8, 1'b0, 1'b0, 391, 3);
    check("repeat_latency", rep_lat, 16'd70);
    check("first_latency", first_lat, 16'd461);
    apply(3, 1'b0, 1'b0, 536, 1);
    check("scan_period", 16'(period), 16'd561);
    check("repeat_latency", rep_lat, 16'd50);
    apply(3, 1'b1, 1'b1, 1000, 255);
    check("scan_period", 16'(period), 16'd561);
    check("repeat_latency", rep_lat, 16'd14080);
    check("first_latency", first_lat, 16'd14586);
    $display("test scan table done");
  endtask

  task automatic test_banks();
    for (int s = 0; s < 8; s++) begin
      tspm_host_model_inst.bank_write(3'(s));
      @(negedge clk_sys_i);
      check("bank", 16'(bank), 16'(s < 5 ? s : 4));
      check("bank_visible", 16'(visible), 16'(1 << (s < 5 ? s : 4)));
    end
    tspm_host_model_inst.bank_write(3'h0);
    @(negedge clk_sys_i);
    check("bank", 16'(bank), 16'h0000);
    $display("test banks done");
  endtask

  task automatic test_deep_sleep();
    int k;
    touch_raw_i = 10'h3ff;
    tspm_host_model_inst.set_line(1'b1);
    repeat (10) @(negedge clk_sys_i);
    check("in_deep_sleep", 16'(deep), 16'h0000);
    tspm_host_model_inst.set_line(1'b0);
    fork
      tspm_host_model_inst.req_deep_sleep();
      begin
        repeat (4) @(negedge clk_sys_i);
        check("deep_sleep_req", 16'(req), 16'h0001);
      end
    join
    for (k = 0; k < 20 && deep !== 1'b1; k++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    check("in_deep_sleep", 16'(deep), 16'h0001);
    check("deep_sleep_req", 16'(req), 16'h0000);
    check("blocks_on", 16'(blocks_on), 16'h0000);
    check("scanning", 16'(scanning), 16'h0000);
    check("scan_start", 16'(start), 16'h0000);
    check("touch_status", 16'(status), 16'h0000);
    tspm_host_model_inst.wake();
    for (k = 0; k < 20 && deep !== 1'b0; k++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    check("in_deep_sleep", 16'(deep), 16'h0000);
    check("report_en", 16'(report_en), 16'h0000);
    check("touch_status", 16'(status), 16'h0000);
    $display("test deep sleep done");
  endtask

  // -------------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    test_reset();
    test_scan_table();
    test_banks();
    test_deep_sleep();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    complete_run();
  end
endmodule
